/* design/pfd_pkg.sv */
`default_nettype none
package pfd_pkg;
  // Clock rate and default minimum pulse width
  localparam int CLK_PERIOD_NS = 20;
  localparam int MIN_PULSE_NS = 50;
  // Least time rounds up to whole cycles, never below one
  localparam int MIN_PULSE_CYC_RAW =
    (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_PULSE_CYC =
    (MIN_PULSE_CYC_RAW < 1) ? 1 : MIN_PULSE_CYC_RAW;
  // Width of the pulse-width counter
  localparam int WIDTH_BITS = 8;
  // Default reference divide ratio
  localparam int REF_DIV_DEFAULT = 2;
  localparam int REF_DIV_BITS = 16;

  // Correction outputs travelling together
  typedef struct packed {
    logic lead;   // Reference leads feedback
    logic lag;    // Reference lags feedback
  } pfd_corr_t;

  // Three-state output as sourcing and sinking driver enables
  typedef struct packed {
    logic src_en;  // Sourcing driver on
    logic snk_en;  // Sinking driver on
  } pfd_drive_t;
endpackage : pfd_pkg
`default_nettype wire

/* design/pfd_detector.sv */
`default_nettype none
// Operation
// - Reference is oscillator divided by programmed ratio
// - Narrow pulse marks each reference and feedback rise
// - Lead pulse width equals reference lead time
// - Lag pulse width equals reference lag time
// - Lead set on lead, cleared by feedback pulse
// - Lag set on lag, cleared by reference pulse
// - Error output high lead, low lag, else float
// - Lock detect combines pulses, always driven
// - Opposite output still gives minimum pulse
// - Locked gives minimum pulses on both outputs
// - In phase both error drivers briefly on
// - Locked error output floats but for brief low overlaps, unlocked gives pulses
// - Described polarities hold with polarity select low
// - Configurable delay sets minimum pulse width
module pfd_detector #(
  parameter int MIN_CYC = pfd_pkg::MIN_PULSE_CYC,
  parameter int REF_DIV_W = pfd_pkg::REF_DIV_BITS
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic osc_i,                    // Oscillator pin input
  input wire logic [REF_DIV_W-1:0] ref_div_i,  // Programmed ratio
  input wire logic divided_feedback_i,        // Divided VCO pin input
  input wire logic [pfd_pkg::WIDTH_BITS-1:0] pulse_cyc_i, // Min width
  input wire logic polarity_select_i,         // Sense of outputs
  output logic divided_reference_o,           // Divided reference
  output logic lead_pulse_out_o,              // Lead output
  output logic lag_pulse_out_o,               // Lag output
  output logic tristate_error_out_o,          // Error pin value
  output logic tristate_error_oe_o,           // Error pin enable
  output logic lock_detect_out_o,             // Lock summation
  output pfd_pkg::pfd_drive_t drivers_o       // Raw driver enables
);

  // Elaboration-time checks
  if (MIN_CYC < 1) $error("MIN_CYC must be at least one");
  if (REF_DIV_W < 2) $error("REF_DIV_W too small");
  if (MIN_CYC > 2**pfd_pkg::WIDTH_BITS - 1) $error("MIN_CYC too large");

  // Zero width request falls back to one cycle
  function automatic logic [pfd_pkg::WIDTH_BITS-1:0] clamp_w(
    input logic [pfd_pkg::WIDTH_BITS-1:0] w);
    clamp_w = (w == '0) ? 8'h01 : w;
  endfunction : clamp_w

  // Synchronisers for pin inputs
  logic [1:0] osc_sync_q;
  logic [1:0] fb_sync_q;
  logic fb_prev_q;
  logic osc_prev_q;

  // Previous-value flops reset low, the idle level of both pins,
  // so no false edge follows the release of reset
  // Pin inputs pass two flops before any logic reads them
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      osc_sync_q <= 2'h0;
      fb_sync_q <= 2'h0;
      osc_prev_q <= 1'b0;
      fb_prev_q <= 1'b0;
    end
    else
    begin
      osc_sync_q <= {osc_sync_q[0], osc_i};
      fb_sync_q <= {fb_sync_q[0], divided_feedback_i};
      osc_prev_q <= osc_sync_q[1];
      fb_prev_q <= fb_sync_q[1];
    end
  end

  // Reference divider: toggle counter on oscillator rises
  logic [REF_DIV_W-1:0] div_cnt_q;
  logic [REF_DIV_W-1:0] div_cnt_d;
  logic ref_q;
  logic ref_d;
  logic ref_prev_q;
  wire osc_rise = osc_sync_q[1] & ~osc_prev_q;
  // Ratios below two leave no half period, so they act as two
  wire [REF_DIV_W-1:0] div_eff =
    (ref_div_i < 2) ? REF_DIV_W'(2) : ref_div_i;
  wire div_wrap = (div_cnt_q >= div_eff - REF_DIV_W'(1));
  // High for first half of the divided period
  wire [REF_DIV_W-1:0] div_half = div_eff >> 1;

  // A ratio lowered mid-period wraps at once instead of running on
  assign div_cnt_d = !osc_rise ? div_cnt_q :
    (div_wrap ? '0 : div_cnt_q + REF_DIV_W'(1));
  assign ref_d = !osc_rise ? ref_q : (div_cnt_d < div_half);

  // Divider state
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      div_cnt_q <= '0;
      ref_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end
    else
    begin
      div_cnt_q <= div_cnt_d;
      ref_q <= ref_d;
      ref_prev_q <= ref_q;
    end
  end

  // Edge pulses: one cycle wide, marking each rise
  // Only second synchroniser stages feed them, keeping metastability out
  wire ref_edge = ref_q & ~ref_prev_q;
  wire fb_edge = fb_sync_q[1] & ~fb_prev_q;

  // Lead/lag latches, set by the earlier edge, cleared by the later
  logic lead_q;
  logic lag_q;
  logic lead_d;
  logic lag_d;
  // An edge with the other latch clear means this input came first
  // Set and clear never meet in one cycle: each set excludes the
  // clearing edge, so no priority question arises
  wire lead_set = ref_edge & ~fb_edge & ~lag_q;
  wire lag_set = fb_edge & ~ref_edge & ~lead_q;
  assign lead_d = fb_edge ? 1'b0 : (lead_set | lead_q);
  assign lag_d = ref_edge ? 1'b0 : (lag_set | lag_q);

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lead_q <= 1'b0;
      lag_q <= 1'b0;
    end
    else
    begin
      lead_q <= lead_d;
      lag_q <= lag_d;
    end
  end

  // Minimum-width stretchers, one per input, retriggered by its edge
  localparam int WB = pfd_pkg::WIDTH_BITS;
  logic [WB-1:0] ref_min_q;
  logic [WB-1:0] fb_min_q;
  logic [WB-1:0] ref_min_d;
  logic [WB-1:0] fb_min_d;
  wire [WB-1:0] width = clamp_w(pulse_cyc_i);
  // Width counts from the edge cycle itself, so load width minus one
  assign ref_min_d = ref_edge ? width - WB'(1) :
    ((ref_min_q != '0) ? ref_min_q - WB'(1) : '0);
  assign fb_min_d = fb_edge ? width - WB'(1) :
    ((fb_min_q != '0) ? fb_min_q - WB'(1) : '0);
  // Each output carries only the pulse of its own input, so a lead
  // ends at the feedback edge instead of running on for the width
  wire ref_min_now = ref_edge | (ref_min_q != '0);
  wire fb_min_now = fb_edge | (fb_min_q != '0);

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ref_min_q <= '0;
      fb_min_q <= '0;
    end
    else
    begin
      ref_min_q <= ref_min_d;
      fb_min_q <= fb_min_d;
    end
  end

  // Raw correction terms: latch plus its own input's minimum pulse
  pfd_pkg::pfd_corr_t corr;
  assign corr.lead = lead_d | ref_min_now;
  assign corr.lag = lag_d | fb_min_now;

  // Polarity select swaps the correction sense when high
  // Swapping ahead of the drivers keeps pin and lock sum consistent
  pfd_pkg::pfd_corr_t sensed;
  assign sensed.lead = polarity_select_i ? corr.lag : corr.lead;
  assign sensed.lag = polarity_select_i ? corr.lead : corr.lag;

  // Both drivers on together only while a minimum pulse overlaps the other output
  pfd_pkg::pfd_drive_t drv;
  assign drv.src_en = sensed.lead;
  assign drv.snk_en = sensed.lag;
  // Overlap: pin enabled and driven low
  wire err_oe = drv.src_en | drv.snk_en;
  wire err_val = drv.src_en & ~drv.snk_en;
  // Lock detect: high on lead, low on lag, holds otherwise
  // Holding keeps it from chattering while both outputs pulse
  // together in lock
  wire ld_val = (drv.src_en ^ drv.snk_en) ? drv.src_en
    : lock_detect_out_o;

  // Output flops; every output from a register
  // Costs one clock of latency, but keeps decode glitches off the
  // pins that drive the loop filter
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      divided_reference_o <= 1'b0;
      lead_pulse_out_o <= 1'b0;
      lag_pulse_out_o <= 1'b0;
      tristate_error_out_o <= 1'b0;
      tristate_error_oe_o <= 1'b0;
      lock_detect_out_o <= 1'b0;
      drivers_o <= '0;
    end
    else
    begin
      divided_reference_o <= ref_d;
      lead_pulse_out_o <= sensed.lead;
      lag_pulse_out_o <= sensed.lag;
      tristate_error_out_o <= err_val;
      tristate_error_oe_o <= err_oe;
      lock_detect_out_o <= ld_val;
      drivers_o <= drv;
    end
  end

endmodule : pfd_detector
`default_nettype wire

/* testbench/pfd_detector_monitor.sv */
`default_nettype none
module pfd_detector_monitor (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [pfd_pkg::WIDTH_BITS-1:0] pulse_cyc_i,
  input wire logic polarity_select_i,
  input wire logic lead_pulse_out_o,
  input wire logic lag_pulse_out_o,
  input wire logic tristate_error_out_o,
  input wire logic tristate_error_oe_o,
  input wire logic lock_detect_out_o,
  input wire pfd_pkg::pfd_drive_t drivers_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Short aliases keep each property on two lines
  wire logic ld = lead_pulse_out_o;
  wire logic lg = lag_pulse_out_o;
  wire logic oe = tristate_error_oe_o;
  wire logic ev = tristate_error_out_o;
  wire logic pl = polarity_select_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // Minimum pulse held for three clocks
  sequence s_hold3(x); x [*3]; endsequence
  a_idle_float: assert property (!ld && !lg |-> !oe)
    else $error("error pin driven while idle");
  a_src_high: assert property (drivers_o == 2'h2 |-> oe && ev)
    else $error("sourcing driver without high pin");
  a_snk_low: assert property (drivers_o == 2'h1 |-> oe && !ev)
    else $error("sinking driver without low pin");
  a_both_on: assert property (drivers_o == 2'h3 |-> oe && !ev)
    else $error("overlap not driven");
  a_none_float: assert property (drivers_o == 2'h0 |-> !oe)
    else $error("pin driven with no driver on");
  a_lead_sum: assert property (!pl && ld && !lg |-> lock_detect_out_o)
    else $error("lock sum not high on lead");
  a_lag_sum: assert property (!pl && lg && !ld |-> !lock_detect_out_o)
    else $error("lock sum not low on lag");
  a_lead_min: assert property ($rose(ld) && pulse_cyc_i == 8'h03
    |-> s_hold3(ld)) else $error("lead pulse too short");
  a_lag_min: assert property ($rose(lg) && pulse_cyc_i == 8'h03
    |-> s_hold3(lg)) else $error("lag pulse too short");
endmodule : pfd_detector_monitor
bind pfd_detector pfd_detector_monitor u_mon (.clock_i(clock_i),
  .rst_b_i(rst_b_i), .pulse_cyc_i(pulse_cyc_i),
  .polarity_select_i(polarity_select_i),
  .lead_pulse_out_o(lead_pulse_out_o), .lag_pulse_out_o(lag_pulse_out_o),
  .tristate_error_out_o(tristate_error_out_o),
  .tristate_error_oe_o(tristate_error_oe_o),
  .lock_detect_out_o(lock_detect_out_o), .drivers_o(drivers_o));
`default_nettype wire

/* testbench/pfd_vco_model.sv */
`default_nettype none
module pfd_vco_model (
  input wire logic clock_i,
  input wire logic err_i,
  input wire logic oe_i,
  output logic fb_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int half_q = 6; // Half period in clocks, minus one
  int cnt_q = 0; // Clocks since last toggle
  initial fb_o = 1'b0;
  // Pump moves the period; clamp keeps each half period at least three clocks
  always @(negedge clock_i)
  begin
    if (oe_i && err_i && half_q > 2)
      half_q <= half_q - 1;
    else if (oe_i && !err_i && half_q < 20)
      half_q <= half_q + 1;
    cnt_q <= (cnt_q >= half_q) ? 0 : cnt_q + 1;
    if (cnt_q >= half_q)
      fb_o <= ~fb_o;
  end
endmodule : pfd_vco_model
`default_nettype wire

/* testbench/pfd_detector_tb_top.sv */
`default_nettype none
module pfd_detector_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, rst_b_i = 0, osc_i = 0, run = 0, lp = 0, gp = 0;
  logic fb_tb = 0, sel = 0, polarity_select = 0, fb_m, ro, lead, lag, ev, oe, ld;
  logic [15:0] div = 16'h0002; // Reference ratio
  logic [7:0] pc = 8'h03; // Minimum width in clocks
  pfd_pkg::pfd_drive_t drv;
  int err_count = 0, checks_done = 0, cyc = 0, n, m, nl, ng;
  // Expected minimum width; zero behaves as one
  function automatic int ew(input logic [7:0] p);
    return (p == 8'h00) ? 1 : int'(p);
  endfunction : ew
  initial forever #10 clock_i = ~clock_i;
  // Oscillator pin toggles at the falling edge while running
  always @(negedge clock_i) if (run) osc_i <= ~osc_i;
  // Rising-edge counters and hang guard
  always @(posedge clock_i)
  begin
    lp <= lead;
    gp <= lag;
    nl <= nl + int'(lead && !lp);
    ng <= ng + int'(lag && !gp);
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_count++;
      test_done();
    end
  end
  pfd_detector dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .osc_i(osc_i),
    .ref_div_i(div), .divided_feedback_i(sel ? fb_tb : fb_m),
    .pulse_cyc_i(pc), .polarity_select_i(polarity_select), .divided_reference_o(ro),
    .lead_pulse_out_o(lead), .lag_pulse_out_o(lag),
    .tristate_error_out_o(ev), .tristate_error_oe_o(oe),
    .lock_detect_out_o(ld), .drivers_o(drv));
  pfd_vco_model u_vco (.clock_i(clock_i), .err_i(ev), .oe_i(oe),
    .fb_o(fb_m));
  task automatic chk(input logic c, input string s);
    checks_done++;
    if (c !== 1'b1)
    begin
      err_count++;
      $display("BAD %0t %s", $time, s);
    end
  endtask : chk
  // Wait for a level under a bound; n holds the clocks spent
  task automatic wl(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 400)
    begin
      @(negedge clock_i);
      n++;
    end
  endtask : wl
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  initial
  begin
    void'($urandom(73473));
    sel = 1;
    repeat (2) @(negedge clock_i);
    chk(lead === 0 && oe === 0 && ld === 0, "reset");
    rst_b_i = 1;
    // Reference first, feedback held low
    div = 16'(2 + $urandom % 3);
    // Zero acts as one; widths stay below the shortest reference period
    pc = 8'($urandom % 4);
    run = 1;
    wl(lead, 1);
    run = 0;
    repeat (ew(pc) + 6) @(negedge clock_i);
    chk(lead && !lag && oe && ev && ld, "lead state");
    fb_tb = 1;
    wl(lag, 1);
    chk(!lead, "lead ends at feedback edge");
    wl(lag, 0);
    chk(n == ew(pc), "lag min width");
    repeat (2) @(negedge clock_i);
    chk(!lead && !oe, "lead cleared");
    $display("lead test done");
    // Feedback first with swapped sense
    fb_tb = 0;
    polarity_select = 1;
    repeat (4) @(negedge clock_i);
    fb_tb = 1;
    repeat (ew(pc) + 6) @(negedge clock_i);
    chk((lead ^ lag) && oe && ev, "swapped sense");
    run = 1;
    wl(oe, 0);
    chk(n < 400, "lag cleared by reference");
    $display("lag test done");
    // Closed loop with the model; random ratio
    polarity_select = 0;
    sel = 0;
    pc = 8'h03;
    repeat (4)
    begin
      div = 16'(2 + $urandom % 3);
      // Skip a half-finished period; the oscillator pin spans two clocks
      wl(ro, 0);
      wl(ro, 1);
      wl(ro, 0);
      m = n;
      wl(ro, 1);
      chk(m + n == 2 * int'(div), "reference period");
      nl = 0;
      ng = 0;
      repeat (1500) @(negedge clock_i);
      chk(nl > 0 && ng > 0, "both outputs pulse");
    end
    $display("loop test done");
    test_done();
  end
endmodule : pfd_detector_tb_top
`default_nettype wire
